// >>> src/rsp_rx_port.sv
// receive stream port: packs received qwords onto the user stream,
// with sideband codes, strobes and a small register/interrupt block.
// assumes the packet source, user logic and register master share clk_sys.
`timescale 1ns/1ns
`include "rsp_regs.svh"

module rsp_rx_port #(
    parameter int DATA_W = 128,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic inValid,
    input wire logic [63:0] inData,
    input wire logic inSop,
    input wire logic inEop,
    input wire logic inHalf,
    input wire logic inPoison,
    input wire logic inEcrcErr,
    output logic inReady,
    output logic [DATA_W-1:0] rxData,
    output logic [DATA_W/8-1:0] rxStrobe,
    output logic rxLast,
    output logic rxValid,
    input wire logic rxReady,
    output logic [4:0] rxStartPosCode,
    output logic [4:0] rxEndPosCode,
    output logic rxErrFwd,
    output logic rxEcrcErr,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic irq
);

    localparam int STRB_W = DATA_W / 8;
    localparam int CNT_W = $clog2(DEPTH + 1);

    // ****************************************************************
    // qword holding store
    // ****************************************************************
    rsp_pkg::rsp_qword_s ent_q [DEPTH];
    rsp_pkg::rsp_qword_s ent_d [DEPTH];
    rsp_pkg::rsp_qword_s inEntry;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic inReady_q;
    logic inReady_d;
    logic ctrlEn_q;
    logic ctrlEn_d;

    wire logic push = inValid && inReady_q;
    wire logic [1:0] popCnt;
    wire rsp_pkg::rsp_qword_s e0 = ent_q[0];
    wire rsp_pkg::rsp_qword_s e1 = ent_q[1];
    wire logic have1 = cnt_q >= CNT_W'(1);
    wire logic have2 = cnt_q >= CNT_W'(2);

    assign inEntry = '{data: inData, sop: inSop, eop: inEop,
                       half: inHalf, poison: inPoison, ecrc: inEcrcErr};

    // ****************************************************************
    // output slot and beat formation
    // ****************************************************************
    logic rxValid_q;
    logic rxValid_d;
    logic [DATA_W-1:0] rxData_q;
    logic [STRB_W-1:0] rxStrobe_q;
    logic rxLast_q;
    logic [4:0] sof_q;
    logic [4:0] eof_q;
    logic errFwd_q;
    logic ecrc_q;

    // slot frees when empty or on a transfer, so a waiting beat holds still
    wire logic slotFree = !rxValid_q || rxReady;
    wire logic xfer = rxValid_q && rxReady;
    wire logic emitPair;
    wire logic emitSolo;
    wire logic emit = emitPair || emitSolo;

    wire logic [DATA_W-1:0] beatData;
    wire logic [STRB_W-1:0] beatStrb;
    wire logic beatLast;
    wire logic [4:0] beatSof;
    wire logic [4:0] beatEof;
    wire logic beatErr;
    wire logic beatEcrc;

    generate
        if (DATA_W == 128) begin : g_wide
            // two consecutive qwords share a beat; an end in the lower half
            // followed by a start in the upper half is a straddle
            assign emitPair = slotFree && have2;
            // a lone ending qword goes out rather than wait for a partner
            assign emitSolo = slotFree && have1 && !have2 && e0.eop;
            assign beatData = {emitPair ? e1.data : 64'h0, e0.data};
            assign beatStrb = {STRB_W{1'b1}};
            assign beatSof = e0.sop ? `RSP_SOF_LO :
                             (emitPair && e1.sop) ? `RSP_SOF_HI :
                             `RSP_SOF_NONE;
            assign beatEof = e0.eop ? (e0.half ? `RSP_EOF_B3 : `RSP_EOF_B7) :
                             (emitPair && e1.eop) ?
                             (e1.half ? `RSP_EOF_B11 : `RSP_EOF_B15) :
                             `RSP_EOF_NONE;
            assign beatLast = e0.eop || (emitPair && e1.eop);
            // the starting packet owns the flag in a straddled beat
            assign beatErr = (emitPair && e1.sop) ? e1.poison
                                                  : e0.poison;
            assign beatEcrc = e0.eop ? e0.ecrc
                                     : (emitPair && e1.eop && e1.ecrc);
        end else begin : g_narrow
            assign emitPair = 1'b0;
            assign emitSolo = slotFree && have1;
            assign beatData = e0.data;
            // a half qword at the end leaves only the low four bytes
            assign beatStrb = (e0.eop && e0.half) ? `RSP_STRB_LO
                                                  : `RSP_STRB_FULL;
            assign beatSof = `RSP_SOF_NONE;
            assign beatEof = `RSP_EOF_NONE;
            assign beatLast = e0.eop;
            assign beatErr = e0.poison;
            assign beatEcrc = e0.eop && e0.ecrc;
        end
    endgenerate

    assign popCnt = emitPair ? 2'h2 : (emitSolo ? 2'h1 : 2'h0);
    // valid drops whenever the slot frees with nothing to show
    assign rxValid_d = slotFree ? emit : rxValid_q;

    // ****************************************************************
    // store update
    // ****************************************************************
    // new qword lands just behind what survives this cycle's pop
    wire logic [CNT_W-1:0] wrSlot = CNT_W'(int'(cnt_q) - int'(popCnt));

    assign cnt_d = CNT_W'(int'(cnt_q) - int'(popCnt) + int'(push));
    // registered ready: room is judged on next cycle's fill level
    assign inReady_d = ctrlEn_q && (int'(cnt_d) < DEPTH);

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_ent
            // an entry past the fill level keeps a stale value, never read
            localparam int SRC1 = (i + 1 < DEPTH) ? i + 1 : i;
            localparam int SRC2 = (i + 2 < DEPTH) ? i + 2 : i;
            wire rsp_pkg::rsp_qword_s shifted =
                (popCnt == 2'h2) ? ent_q[SRC2] :
                (popCnt == 2'h1) ? ent_q[SRC1] : ent_q[i];
            wire logic takeIn = push && (wrSlot == CNT_W'(i));
            assign ent_d[i] = takeIn ? inEntry : shifted;
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    ent_q[i] <= '0;
                end else begin
                    ent_q[i] <= ent_d[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            inReady_q <= 1'b0;
            rxValid_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            inReady_q <= inReady_d;
            rxValid_q <= rxValid_d;
        end
    end

    // beat fields load only with a new beat, otherwise they hold
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxData_q <= '0;
            rxStrobe_q <= '0;
            rxLast_q <= 1'b0;
            sof_q <= `RSP_SOF_NONE;
            eof_q <= `RSP_EOF_NONE;
            errFwd_q <= 1'b0;
            ecrc_q <= 1'b0;
        end else if (emit) begin
            rxData_q <= beatData;
            rxStrobe_q <= beatStrb;
            rxLast_q <= beatLast;
            sof_q <= beatSof;
            eof_q <= beatEof;
            errFwd_q <= beatErr;
            ecrc_q <= beatEcrc;
        end
    end

    // ****************************************************************
    // registers and interrupt
    // ****************************************************************
    logic [`RSP_ST_W-1:0] status_q;
    logic [`RSP_ST_W-1:0] status_d;
    logic [`RSP_ST_W-1:0] mask_q;
    logic [`RSP_ST_W-1:0] mask_d;
    logic [`RSP_PKTCNT_W-1:0] pktCnt_q;
    logic [`RSP_PKTCNT_W-1:0] pktCnt_d;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic irq_q;
    logic irq_d;
    logic pktPoison_q;
    logic pktPoison_d;

    wire logic selCtrl = regAddr == `RSP_ADDR_CTRL;
    wire logic selStatus = regAddr == `RSP_ADDR_STATUS;
    wire logic selMask = regAddr == `RSP_ADDR_MASK;
    wire logic selCnt = regAddr == `RSP_ADDR_PKTCNT;
    wire logic [`RSP_ST_W-1:0] clrBits =
        (regWr && selStatus) ? regWrData[`RSP_ST_W-1:0] : '0;
    wire logic [`RSP_ST_W-1:0] events;

    // a straddled beat's flag names the new packet, so the ending one's
    // poison is the flag of the beat taken before it
    wire logic endPoison = (sof_q == `RSP_SOF_HI) ? pktPoison_q : errFwd_q;
    assign pktPoison_d = xfer ? errFwd_q : pktPoison_q;

    // events count only on beats the user actually took
    assign events[`RSP_ST_POISON_BIT] = xfer && rxLast_q && endPoison;
    assign events[`RSP_ST_ECRC_BIT] = xfer && ecrc_q;
    assign events[`RSP_ST_PKT_BIT] = xfer && rxLast_q;

    // set after clear, so an event in the clearing cycle survives
    assign status_d = (status_q & ~clrBits) | events;
    assign mask_d = (regWr && selMask) ? regWrData[`RSP_ST_W-1:0] : mask_q;
    assign ctrlEn_d = (regWr && selCtrl) ? regWrData[`RSP_CTRL_EN_BIT]
                                         : ctrlEn_q;
    assign pktCnt_d = pktCnt_q + `RSP_PKTCNT_W'(events[`RSP_ST_PKT_BIT]);
    assign irq_d = |(status_d & mask_d);
    // unmapped addresses read as zero
    assign rdData_d = !regRd ? 32'h0 :
                      selCtrl ? {31'h0, ctrlEn_q} :
                      selStatus ? {{(32-`RSP_ST_W){1'b0}}, status_q} :
                      selMask ? {{(32-`RSP_ST_W){1'b0}}, mask_q} :
                      selCnt ? {{(32-`RSP_PKTCNT_W){1'b0}}, pktCnt_q} :
                      32'h0;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_q <= `RSP_ST_RST;
            mask_q <= `RSP_MASK_RST;
            ctrlEn_q <= `RSP_CTRL_RST;
            pktCnt_q <= '0;
            rdData_q <= 32'h0;
            irq_q <= 1'b0;
            pktPoison_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            ctrlEn_q <= ctrlEn_d;
            pktCnt_q <= pktCnt_d;
            rdData_q <= rdData_d;
            irq_q <= irq_d;
            pktPoison_q <= pktPoison_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign inReady = inReady_q;
    assign rxValid = rxValid_q;
    assign rxData = rxData_q;
    assign rxStrobe = rxStrobe_q;
    assign rxLast = rxLast_q;
    assign rxStartPosCode = sof_q;
    assign rxEndPosCode = eof_q;
    assign rxErrFwd = errFwd_q;
    assign rxEcrcErr = ecrc_q;
    assign regRdData = rdData_q;
    assign irq = irq_q;

endmodule

// >>> common/rsp_regs.svh
// constants of the receive stream port: register map, field positions,
// reset values and sideband position codes.
// assumes a plain register port with byte addresses and 32-bit data.
//
// Notes on behaviour
// - last output marks the final beat of each packet, only with valid.
// - data bus is 64 or 128 bits wide; data means nothing without valid.
// - on the 128-bit bus a packet may start in the lower or upper half.
// - on 64 bits, strobe bit n qualifies data byte n, bit 0 lowest.
// - 64-bit strobe is all ones except a last beat, which may be 0x0f.
// - 128-bit start code rides bits 14:10, end code bits 21:17.
// - start code top bit flags a new packet, low four bits its byte.
// - start code is only 10000, 11000 or 00000 binary.
// - end code top bit flags a packet end, low four bits its last byte.
// - end code is 10011, 10111, 11011, 11111, or 00011 when none ends.
// - error-forward stays high for a poisoned packet's whole length.
// - in a straddled beat, error-forward refers to the starting packet.
// - ecrc error flag is raised on the last beat of a failed packet.
// - valid is high only while meaningful data is presented.
// - a beat transfers only on an edge with valid and ready both high.
`ifndef RSP_REGS_SVH
`define RSP_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define RSP_ADDR_CTRL 8'h00
`define RSP_ADDR_STATUS 8'h04
`define RSP_ADDR_MASK 8'h08
`define RSP_ADDR_PKTCNT 8'h0c

`define RSP_CTRL_EN_BIT 0
`define RSP_CTRL_RST 1'b1
`define RSP_ST_POISON_BIT 0
`define RSP_ST_ECRC_BIT 1
`define RSP_ST_PKT_BIT 2
`define RSP_ST_W 3
`define RSP_ST_RST 3'h0
`define RSP_MASK_RST 3'h0
`define RSP_PKTCNT_W 16

// ****************************************************************
// sideband codes and strobe patterns
// ****************************************************************
`define RSP_SOF_LO 5'h10
`define RSP_SOF_HI 5'h18
`define RSP_SOF_NONE 5'h00
`define RSP_EOF_B3 5'h13
`define RSP_EOF_B7 5'h17
`define RSP_EOF_B11 5'h1b
`define RSP_EOF_B15 5'h1f
`define RSP_EOF_NONE 5'h03
`define RSP_STRB_FULL 8'hff
`define RSP_STRB_LO 8'h0f

`endif

// >>> common/rsp_pkg.sv
// types shared by the receive stream port.
// assumes the packet source hands over one 64-bit qword at a time.
package rsp_pkg;

    // one qword of a received packet with its framing flags
    typedef struct packed {
        logic [63:0] data;
        logic sop;
        logic eop;
        logic half;
        logic poison;
        logic ecrc;
    } rsp_qword_s;

endpackage

// >>> sim/rsp_user_sink.sv
// user-side model: drives ready on the receive stream.
// assumes clk_sys and resetn shared with the port.
`timescale 1ns/1ns
module rsp_user_sink (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic slow,
    input wire logic hold,
    output logic rxReady
);
    // ****************************************************************
    // ready pattern
    // ****************************************************************
    logic [1:0] phase_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) phase_q <= 2'h0;
        else phase_q <= phase_q + 2'h1;
    end
    // slow mode takes one beat in four, so stalls hit every field
    // hold parks the sink so qwords pile up behind a waiting beat
    assign rxReady = !hold && (!slow || (phase_q == 2'h3));
endmodule

// >>> sim/rsp_rx_port_asserts.sv
// checker for the receive stream port, bound to its ports.
// assumes a single clk_sys domain and the 128-bit build.
`timescale 1ns/1ns
module rsp_rx_port_asserts #(
    parameter int DATA_W = 128
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic inValid,
    input wire logic inSop,
    input logic inReady,
    input logic [DATA_W-1:0] rxData,
    input logic [DATA_W/8-1:0] rxStrobe,
    input logic rxLast,
    input logic rxValid,
    input wire logic rxReady,
    input logic [4:0] rxStartPosCode,
    input logic [4:0] rxEndPosCode,
    input logic rxErrFwd,
    input logic rxEcrcErr,
    input wire logic regRd,
    input logic [31:0] regRdData
);
    // ****************************************************************
    // stream and register-read properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence beatStall;
        rxValid && !rxReady;
    endsequence
    sequence pktTaken;
        inValid && inReady && inSop ##1 inValid && inReady;
    endsequence
    a_stall_hold: assert property (beatStall |=> rxValid &&
        $stable(rxData) && $stable(rxStrobe) && $stable(rxLast) &&
        $stable(rxErrFwd) &&
        $stable(rxStartPosCode) && $stable(rxEndPosCode) &&
        $stable(rxEcrcErr)) else $error("beat changed while stalled");
    a_start_legal: assert property (rxValid |-> rxStartPosCode
        inside {5'h10, 5'h18, 5'h00}) else $error("bad start code");
    a_end_legal: assert property (rxValid |-> rxEndPosCode inside
        {5'h13, 5'h17, 5'h1b, 5'h1f, 5'h03}) else $error("bad end code");
    a_last_code: assert property (rxValid |-> rxLast ==
        rxEndPosCode[4]) else $error("last disagrees with end code");
    a_ecrc_end: assert property (rxValid && rxEcrcErr |-> rxLast)
        else $error("ecrc flag off the end beat");
    a_strobe_full: assert property (rxValid |-> &rxStrobe)
        else $error("strobe not full on wide bus");
    a_upper_start: assert property (rxValid &&
        rxStartPosCode == 5'h18 |-> rxEndPosCode inside {5'h13, 5'h17})
        else $error("upper start without lower end");
    a_pkt_out: assert property (pktTaken |->
        ##[1:40] rxValid && rxStartPosCode[4])
        else $error("accepted packet never started");
    a_poison_run: assert property (rxValid && rxReady && !rxLast &&
        rxErrFwd |=> !rxValid || rxErrFwd || rxStartPosCode == 5'h18)
        else $error("error-forward dropped mid packet");
    a_rd_once: assert property (!regRd |=> regRdData == 32'h0)
        else $error("read data outside its cycle");
endmodule

bind rsp_rx_port rsp_rx_port_asserts #(.DATA_W(DATA_W)) uChk (
    .clk_sys, .resetn, .inValid, .inSop, .inReady, .rxData, .rxStrobe,
    .rxLast, .rxValid, .rxReady, .rxStartPosCode, .rxEndPosCode,
    .rxErrFwd, .rxEcrcErr, .regRd, .regRdData
);

// >>> sim/tb_tlp_receive_stream_port.sv
// testbench for the receive stream port, 128-bit build.
// assumes the user sink model and the bound checker.
`timescale 1ns/1ns
`include "rsp_regs.svh"
module tb_tlp_receive_stream_port;
    // ****************************************************************
    // signals, design and partner
    // ****************************************************************
    logic clk_sys = 1'b0, resetn = 1'b0, slow = 1'b0, hold = 1'b0;
    logic inValid = 1'b0, inSop = 1'b0, inEop = 1'b0, inHalf = 1'b0;
    logic inPoison = 1'b0, inEcrcErr = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [63:0] inData = 64'h0;
    logic [7:0] regAddr = 8'h0;
    logic [31:0] regWrData = 32'h0, regRdData;
    logic inReady, rxLast, rxValid, rxReady, rxErrFwd, rxEcrcErr, irq;
    logic [127:0] rxData;
    logic [15:0] rxStrobe;
    logic [4:0] rxStartPosCode, rxEndPosCode;
    logic [140:0] bQ[$];
    int nErrors = 0, nTests = 0;
    typedef struct {int n; logic h, p, c;} rsp_row_s;
    rsp_row_s rows[5] = '{'{2, 0, 0, 0}, '{3, 0, 1, 0}, '{3, 1, 0, 1},
        '{4, 1, 1, 1}, '{5, 0, 0, 1}};
    always #5 clk_sys = ~clk_sys;
    rsp_rx_port #(.DATA_W(128), .DEPTH(2)) DUT (
        .clk_sys, .resetn, .inValid, .inData, .inSop, .inEop, .inHalf,
        .inPoison, .inEcrcErr, .inReady, .rxData, .rxStrobe, .rxLast,
        .rxValid, .rxReady, .rxStartPosCode, .rxEndPosCode, .rxErrFwd,
        .rxEcrcErr, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .irq
    );
    rsp_user_sink uSink (.clk_sys, .resetn, .slow, .hold, .rxReady);
    always @(posedge clk_sys) if (rxValid === 1'b1 && rxReady === 1'b1)
        bQ.push_back({rxStartPosCode, rxEndPosCode, rxLast, rxErrFwd,
            rxEcrcErr, rxData});
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic finishTest;
        if (nErrors == 0 && nTests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [140:0] seen, input logic [140:0] x);
        nTests++;
        if (seen !== x) begin
            nErrors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, x);
        end
    endtask
    task automatic cmp(input int b, input logic [140:0] x,
        input logic [127:0] m);
        check(bQ[b] & {13'h1fff, m}, x & {13'h1fff, m});
    endtask
    function automatic logic [63:0] qw(input int r, input int i);
        return {4{r[7:0], i[7:0]}};
    endfunction
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic regRead(input logic [7:0] a, input logic [31:0] x);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        check(141'(regRdData), 141'(x));
        @(posedge clk_sys);
    endtask
    // source side: a qword holds until the edge that takes it
    task automatic sendPkt(input int r, n, input logic h, p, c);
        for (int i = 0; i < n; i++) begin
            inValid <= 1'b1;
            inData <= qw(r, i);
            inSop <= (i == 0);
            inEop <= (i == n - 1);
            inHalf <= h && (i == n - 1);
            inPoison <= p;
            inEcrcErr <= c && (i == n - 1);
            do @(negedge clk_sys); while (inReady !== 1'b1);
            @(posedge clk_sys);
        end
    endtask
    task automatic drain(input int nb);
        for (int k = 0; k < 100 && bQ.size() < nb; k++) @(posedge clk_sys);
        check(141'(bQ.size()), 141'(nb));
    endtask
    task automatic runRow(input int r, n, input logic h, p, c);
        logic [140:0] x;
        logic [127:0] m;
        logic [4:0] e;
        int nb;
        nb = (n + 1) / 2;
        bQ.delete();
        sendPkt(r, n, h, p, c);
        inValid <= 1'b0;
        drain(nb);
        for (int b = 0; b < nb; b++) begin
            e = (b < nb - 1) ? 5'h03 : 5'h13 | ((n % 2) ? 5'h00 : 5'h08)
                | (h ? 5'h00 : 5'h04);
            // a half qword leaves bytes past the end code undefined
            m = (h && b == nb - 1) ? (128'h1 << (8 * (int'(e[3:0]) + 1)))
                - 128'h1 : '1;
            x = {(b == 0) ? 5'h10 : 5'h00, e, b == nb - 1, p,
                c && b == nb - 1, (2 * b + 1 < n) ? qw(r, 2 * b + 1) : 64'h0,
                qw(r, 2 * b)};
            cmp(b, x, m);
        end
    endtask
    task automatic chkIrq(input logic x);
        @(negedge clk_sys);
        check(141'(irq), 141'(x));
        @(posedge clk_sys);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        #200000;
        nErrors++;
        finishTest();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        check(141'({rxValid, inReady, irq, rxStartPosCode, rxEndPosCode}),
            141'({3'b000, 5'h00, 5'h03}));
        resetn <= 1'b1;
        @(posedge clk_sys);
        regRead(`RSP_ADDR_CTRL, 32'(`RSP_CTRL_RST));
        regRead(`RSP_ADDR_MASK, 32'(`RSP_MASK_RST));
        foreach (rows[i]) begin
            slow <= i[0];
            runRow(i, rows[i].n, rows[i].h, rows[i].p, rows[i].c);
        end
        // clear old events so the ending packet's poison shows alone
        regWrite(`RSP_ADDR_STATUS, 32'h7);
        bQ.delete();
        // a parked sink lets the ending and the starting qword meet
        hold <= 1'b1;
        fork
            begin
                sendPkt(9, 3, 1'b0, 1'b1, 1'b1);
                sendPkt(10, 2, 1'b0, 1'b0, 1'b0);
                inValid <= 1'b0;
            end
            begin
                repeat (12) @(posedge clk_sys);
                hold <= 1'b0;
            end
        join
        drain(3);
        cmp(0, {5'h10, 5'h03, 3'b010, qw(9, 1), qw(9, 0)}, '1);
        cmp(1, {5'h18, 5'h17, 3'b101, qw(10, 0), qw(9, 2)}, '1);
        cmp(2, {5'h00, 5'h17, 3'b100, 64'h0, qw(10, 1)}, '1);
        regRead(`RSP_ADDR_STATUS, 32'h7);
        regRead(`RSP_ADDR_PKTCNT, 32'h7);
        chkIrq(1'b0);
        regWrite(`RSP_ADDR_MASK, 32'h2);
        chkIrq(1'b1);
        regWrite(`RSP_ADDR_STATUS, 32'h2);
        chkIrq(1'b0);
        regRead(`RSP_ADDR_STATUS, 32'h5);
        regRead(8'h10, 32'h0);
        regWrite(`RSP_ADDR_CTRL, 32'h0);
        inValid <= 1'b1;
        inSop <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check(141'({inReady, rxValid}), 141'(0));
        @(posedge clk_sys);
        regWrite(`RSP_ADDR_CTRL, 32'h1);
        runRow(11, 2, 1'b0, 1'b0, 1'b0);
        // reset in mid-run brings every register back to its reset value
        resetn <= 1'b0;
        @(negedge clk_sys);
        check(141'({inReady, irq, rxValid, rxLast, rxEndPosCode}),
            141'({4'h0, 5'h03}));
        @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        regRead(`RSP_ADDR_MASK, 32'(`RSP_MASK_RST));
        regRead(`RSP_ADDR_STATUS, 32'(`RSP_ST_RST));
        regRead(`RSP_ADDR_PKTCNT, 32'h0);
        finishTest();
    end
endmodule
